//--- hw/clock_control.sv
// Clock control top: divide unlock, prescaler, trim register, clock export
//
// Our own choices: the strobed register port and the address map.
`default_nettype none
// Function
// [RULE1] External-drive bit selects external clock on timer oscillator input.
// [RULE2] Programmed export fuse drives clock on export pin, also in reset; the code keeps the pin driven but low in reset, with no clock.
// [RULE3] Exported clock is the post-prescaler system clock.
// [RULE4] Divide code 0..8 gives factor two to the code; above reserved.
// [RULE5] Prescaled clock feeds CPU, flash, I/O and converter domains.
// [RULE6] Divide change makes no glitch and no shorter period.
// [RULE7] New divide takes effect after old period plus one or two new.
// [RULE8] Prescaler counts on the master clock; count not readable.
// [RULE9] Unlock bit sets only on write of 0x80 exactly.
// [RULE10] Software writes divide within four cycles after unlock.
// [RULE11] Unlock clears after four cycles or on divide write.
// [RULE12] Rewriting unlock during window neither extends nor clears it.
// [RULE13] Divide resets to 0 or 3 per divide-by-eight fuse.
// [RULE14] After unlock any divide value is accepted regardless of fuse.
// [RULE15] Software keeps interrupts off during the change sequence.
// [RULE16] Trim loads factory value at reset; software may overwrite.
// [RULE17] Top trim bit selects lower or higher overlapping range.
// [RULE18] Lower seven trim bits tune monotonically within range.
// [RULE19] Software avoids trimming above 8.8 MHz during memory writes.
// [RULE20] Software picks divide keeping clock within maximum frequency.
// [RULE21] Bits 6..4 read zero; reserved code stored but not applied.
module clock_control
    import clk_ctrl_pkg::*;
#(
    parameter logic [7:0] FACTORY_TRIM = TRIM_DEFAULT
) (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       ce,
    input  wire logic [1:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       start_div_eight_fuse,
    input  wire logic       clock_export_fuse,
    input  wire logic       gpio_out,
    input  wire logic       gpio_oe,
    output logic            clock_export_pin_o,
    output logic            clock_export_pin_oe,
    output logic            sys_clk_en,
    output logic [7:0]      rc_osc_trim_o,
    output logic            timer_osc_ext_drive
);
    typedef struct packed {
        unlock_e    ul;
        logic [2:0] ul_cnt;
        logic [3:0] sel;
        logic       sel_load;
        logic [7:0] trim;
        logic       ext_drive;
        logic [7:0] rdata;
        logic       fuse_loaded;
        logic       clk_en;
    } top_state_s;

    // Pin drive kept apart: a fuse-selected export must survive reset
    typedef struct packed {
        logic pin_o;
        logic pin_oe;
    } pin_state_s;

    top_state_s st_r;
    top_state_s st_nxt;
    logic       rst_sync_b;
    logic       tick;
    bus_req_s   req;
    div_cmd_s   cmd;
    logic [7:0] divctl_view;
    pin_state_s pin_r;
    pin_state_s pin_nxt;

    clk_reset_sync u_rst (
        .clk        (clk),
        .rst_b      (rst_b),
        .rst_sync_b (rst_sync_b)
    );

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
    assign cmd = '{sel: st_r.sel, load: st_r.sel_load};

    sysclk_prescaler #(
        .CW (CNT_W)
    ) u_pre (
        .clk        (clk),
        .rst_sync_b (rst_sync_b),
        .ce         (ce),
        .cmd        (cmd),
        .tick       (tick)
    );

    // Unused bits 6..4 read as zero; count state is never exposed
    assign divctl_view = {st_r.ul == UL_OPEN, ZERO3, st_r.sel}; // RULE21

    // Register writes, unlock window and read mux
    always_comb begin
        st_nxt = st_r;
        st_nxt.sel_load = 1'b0;
        st_nxt.rdata = 8'h00;
        // Strap caught once, one cycle after release, not under reset
        if (!st_r.fuse_loaded) begin
            st_nxt.fuse_loaded = 1'b1;
            st_nxt.sel = start_div_eight_fuse ? SEL_RESET_DIV8
                                              : SEL_RESET; // RULE13
            st_nxt.sel_load = 1'b1;
            st_nxt.trim = FACTORY_TRIM; // RULE16
        end
        // Window countdown; no restart while open
        if (st_r.ul == UL_OPEN) begin
            if (st_r.ul_cnt == ONE3) begin
                st_nxt.ul = UL_LOCKED; // RULE11
                st_nxt.ul_cnt = ZERO3;
            end else begin
                st_nxt.ul_cnt = st_r.ul_cnt - ONE3;
            end
        end
        if (req.wr && st_r.fuse_loaded) begin
            case (req.addr)
                ADDR_TRIM: begin
                    st_nxt.trim = req.wdata; // RULE17 RULE18
                end
                ADDR_DIVCTL: begin
                    if (req.wdata == UNLOCK_WORD) begin
                        if (st_r.ul == UL_LOCKED) begin // RULE12
                            st_nxt.ul = UL_OPEN; // RULE9
                            st_nxt.ul_cnt = UNLOCK_CYCLES;
                        end
                    end else if (!req.wdata[UNLOCK_BIT] &&
                                 st_r.ul == UL_OPEN) begin
                        st_nxt.sel = req.wdata[SEL_W-1:0]; // RULE14 RULE10
                        st_nxt.sel_load = 1'b1;
                        st_nxt.ul = UL_LOCKED; // RULE11
                        st_nxt.ul_cnt = ZERO3;
                    end
                end
                ADDR_TIMERCFG: begin
                    st_nxt.ext_drive = req.wdata[EXTDRV_BIT]; // RULE1
                end
                default: begin
                end
            endcase
        end
        if (req.rd) begin
            case (req.addr)
                ADDR_TRIM:     st_nxt.rdata = st_r.trim;
                ADDR_DIVCTL:   st_nxt.rdata = divctl_view;
                ADDR_TIMERCFG: st_nxt.rdata = {1'b0, st_r.ext_drive, 6'h00};
                default:       st_nxt.rdata = 8'h00;
            endcase
        end
        // Divided clock enable drives all synchronous domains and export
        st_nxt.clk_en = tick; // RULE5 RULE3
        pin_nxt.pin_o = clock_export_fuse ? tick : gpio_out; // RULE2 RULE3
        pin_nxt.pin_oe = clock_export_fuse | gpio_oe; // RULE2
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // No reset here, so the fuse keeps the pin driven while reset holds;
    // the tick itself is quiet in reset since the prescaler is cleared
    always_ff @(posedge clk) begin
        if (ce) begin
            pin_r <= pin_nxt; // RULE2
        end
    end

    assign rdata               = st_r.rdata;
    assign sys_clk_en          = st_r.clk_en;
    assign clock_export_pin_o  = pin_r.pin_o;
    assign clock_export_pin_oe = pin_r.pin_oe;
    assign rc_osc_trim_o       = st_r.trim;
    assign timer_osc_ext_drive = st_r.ext_drive;

    // Sequences for the two-write change procedure
    sequence unlock_write_s;
        ce && wr && addr == ADDR_DIVCTL && wdata == UNLOCK_WORD
            && st_r.ul == UL_LOCKED && st_r.fuse_loaded;
    endsequence

    unlock_set_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
        unlock_write_s |=> st_r.ul == UL_OPEN) // RULE9
        else $error("unlock bit not set by exact unlock write");
    unlock_bad_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
        ce && wr && addr == ADDR_DIVCTL && wdata != UNLOCK_WORD
            && st_r.ul == UL_LOCKED |=> st_r.ul == UL_LOCKED) // RULE9
        else $error("unlock bit set by malformed write");
    unlock_timeout_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
        unlock_write_s ##1 (!ce || !wr) [*4] |=> st_r.ul == UL_LOCKED)
        // RULE11
        else $error("unlock window did not close after four cycles");
    unlock_no_extend_a: assert property (@(posedge clk)
        disable iff (!rst_sync_b)
        ce && st_r.ul == UL_OPEN && st_r.ul_cnt == ONE3
            |=> st_r.ul == UL_LOCKED) // RULE12
        else $error("unlock window extended");
    divide_write_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
        ce && wr && addr == ADDR_DIVCTL && !wdata[UNLOCK_BIT]
            && st_r.ul == UL_OPEN
            |=> st_r.sel == $past(wdata[3:0]) && st_r.ul == UL_LOCKED)
        // RULE14
        else $error("divide write after unlock not taken");
    divide_locked_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
        st_r.fuse_loaded && st_r.ul == UL_LOCKED |=> $stable(st_r.sel))
        // RULE10
        else $error("divide changed without unlock");
    fuse_reset_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
        ce && !st_r.fuse_loaded |=> st_r.sel ==
            ($past(start_div_eight_fuse) ? SEL_RESET_DIV8 : SEL_RESET))
        // RULE13
        else $error("divide reset value wrong");
    trim_reset_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
        ce && !st_r.fuse_loaded |=> st_r.trim == FACTORY_TRIM) // RULE16
        else $error("trim not loaded with factory value");
    export_pin_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
        ce && clock_export_fuse |=> clock_export_pin_oe
            && clock_export_pin_o == sys_clk_en) // RULE2
        else $error("export pin not following system clock");
    read_zero_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
        ce && rd && addr == ADDR_DIVCTL |=> rdata[6:4] == ZERO3) // RULE21
        else $error("unused divide bits not zero");

    // Bus requests as the register file takes them
    sequence trim_write_s;
        ce && wr && addr == ADDR_TRIM && st_r.fuse_loaded;
    endsequence

    sequence timer_write_s;
        ce && wr && addr == ADDR_TIMERCFG && st_r.fuse_loaded;
    endsequence

    sequence divctl_read_s;
        ce && rd && addr == ADDR_DIVCTL;
    endsequence

    sequence trim_read_s;
        ce && rd && addr == ADDR_TRIM;
    endsequence

    sequence relock_write_s;
        ce && wr && addr == ADDR_DIVCTL && wdata == UNLOCK_WORD
            && st_r.ul == UL_OPEN;
    endsequence

    // Trim takes any byte; range and fine bits pass straight out
    trim_write_a: assert property ( // RULE17 RULE18
        @(posedge clk) disable iff (!rst_sync_b)
        trim_write_s |=> rc_osc_trim_o == $past(wdata))
        else $error("trim write not taken");

    // Software reads back whatever the trim register holds
    trim_read_a: assert property ( // RULE16
        @(posedge clk) disable iff (!rst_sync_b)
        trim_read_s |=> rdata == $past(st_r.trim))
        else $error("trim read back wrong");

    // External drive select follows its bit of the timer register
    ext_drive_a: assert property ( // RULE1
        @(posedge clk) disable iff (!rst_sync_b)
        timer_write_s |=> timer_osc_ext_drive == $past(wdata[EXTDRV_BIT]))
        else $error("external drive select not taken");

    // Divide view: unlock flag on top, select below, count never shown
    divctl_read_a: assert property ( // RULE9
        @(posedge clk) disable iff (!rst_sync_b)
        divctl_read_s |=> rdata[UNLOCK_BIT] == ($past(st_r.ul) == UL_OPEN)
            && rdata[SEL_W-1:0] == $past(st_r.sel))
        else $error("divide control read back wrong");

    // Read data stand for one cycle only and are zero otherwise
    read_idle_a: assert property ( // RULE21
        @(posedge clk) disable iff (!rst_sync_b)
        ce && !rd |=> rdata == 8'h00)
        else $error("read data not cleared after read cycle");

    // Rewriting the unlock word keeps the countdown going
    relock_a: assert property ( // RULE12
        @(posedge clk) disable iff (!rst_sync_b)
        relock_write_s |=> st_r.ul == UL_LOCKED
            || st_r.ul_cnt == $past(st_r.ul_cnt) - ONE3)
        else $error("unlock window restarted by rewrite");

    // An open window always holds a live count no longer than four
    window_count_a: assert property ( // RULE11
        @(posedge clk) disable iff (!rst_sync_b)
        st_r.ul == UL_OPEN |-> st_r.ul_cnt != ZERO3
            && st_r.ul_cnt <= UNLOCK_CYCLES)
        else $error("unlock window count out of range");

    // A closed window leaves no stale count behind
    window_idle_a: assert property ( // RULE11
        @(posedge clk) disable iff (!rst_sync_b)
        st_r.ul == UL_LOCKED |-> st_r.ul_cnt == ZERO3)
        else $error("stale unlock count while locked");

    // The strap is caught once per reset and never again
    fuse_once_a: assert property ( // RULE13
        @(posedge clk) disable iff (!rst_sync_b)
        st_r.fuse_loaded |=> st_r.fuse_loaded)
        else $error("fuse strap reloaded without reset");

    // A new divide reaches the prescaler as a single load pulse
    divide_load_a: assert property ( // RULE7
        @(posedge clk) disable iff (!rst_sync_b)
        ce && st_r.sel_load |=> !st_r.sel_load)
        else $error("divide load pulse longer than one cycle");

    // Every synchronous domain sees the prescaler tick one cycle later
    clk_en_a: assert property ( // RULE5
        @(posedge clk) disable iff (!rst_sync_b)
        ce |=> sys_clk_en == $past(tick))
        else $error("system clock enable not following prescaler");

    // Without the fuse the pin keeps its normal function
    export_gpio_a: assert property ( // RULE2
        @(posedge clk) disable iff (!rst_sync_b)
        ce && !clock_export_fuse |=> clock_export_pin_o == $past(gpio_out)
            && clock_export_pin_oe == $past(gpio_oe))
        else $error("pin function overridden without export fuse");

    // With the fuse the pin stays driven while reset holds as well
    export_reset_a: assert property ( // RULE2
        @(posedge clk)
        ce && !rst_sync_b && clock_export_fuse |=> clock_export_pin_oe)
        else $error("export pin not driven during reset");

    // A low clock enable freezes every register but the reset synchroniser, counter included
    frozen_a: assert property ( // RULE8
        @(posedge clk) disable iff (!rst_sync_b)
        !ce |=> $stable(st_r) && $stable(pin_r))
        else $error("state moved while clock enable low");
endmodule : clock_control
`default_nettype wire

//--- hw/clk_ctrl_pkg.sv
// Package: register map, field layout, reset values and types of clock control
`default_nettype none
package clk_ctrl_pkg;
    localparam int          ADDR_W        = 2;
    localparam logic [1:0]  ADDR_TRIM     = 2'h0;
    localparam logic [1:0]  ADDR_DIVCTL   = 2'h1;
    localparam logic [1:0]  ADDR_TIMERCFG = 2'h2;
    localparam int          UNLOCK_BIT    = 7;
    localparam int          EXTDRV_BIT    = 6;
    localparam int          SEL_W         = 4;
    localparam logic [3:0]  SEL_RESET     = 4'h0;
    localparam logic [3:0]  SEL_RESET_DIV8 = 4'h3;
    localparam logic [3:0]  SEL_MAX       = 4'h8;
    localparam logic [7:0]  UNLOCK_WORD   = 8'h80;
    localparam logic [2:0]  UNLOCK_CYCLES = 3'h4;
    localparam logic [2:0]  ZERO3         = 3'h0;
    localparam logic [2:0]  ONE3          = 3'h1;
    localparam int          CNT_W         = 8;
    localparam logic [7:0]  CNT_ZERO      = 8'h00;
    localparam logic [7:0]  CNT_ONE       = 8'h01;
    localparam logic [7:0]  TRIM_DEFAULT  = 8'h80;

    typedef enum logic [1:0] {
        UL_LOCKED = 2'b00,
        UL_OPEN   = 2'b01
    } unlock_e;

    // Register bus request
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_s;

    // Divider control handed to the prescaler
    typedef struct packed {
        logic [3:0] sel;
        logic       load;
    } div_cmd_s;
endpackage : clk_ctrl_pkg
`default_nettype wire

//--- hw/clk_reset_sync.sv
// Reset release synchroniser: async assert, two-flop release
`default_nettype none
module clk_reset_sync (
    input  wire logic clk,
    input  wire logic rst_b,
    output logic      rst_sync_b
);
    logic [1:0] sync_r;

    // Release through two flops so the rest sees a clean edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_r <= 2'h0;
        end else begin
            sync_r <= {sync_r[0], 1'b1};
        end
    end

    assign rst_sync_b = sync_r[1];
endmodule : clk_reset_sync
`default_nettype wire

//--- hw/sysclk_prescaler.sv
// Glitch-free power-of-two prescaler producing a clock-enable tick
`default_nettype none
module sysclk_prescaler
    import clk_ctrl_pkg::*;
#(
    parameter int CW = CNT_W
) (
    input  wire logic     clk,
    input  wire logic     rst_sync_b,
    input  wire logic     ce,
    input  wire div_cmd_s cmd,
    output logic          tick
);
    typedef struct packed {
        logic [7:0] cnt;
        logic [7:0] period;
        logic [7:0] pend_period;
        logic       pend;
        logic       tick;
    } pre_state_s;

    pre_state_s st_r;
    pre_state_s st_nxt;

    // Period minus one for a legal code; power of two minus one
    function automatic logic [7:0] period_of(input logic [3:0] sel);
        logic [8:0] p;
        p = 9'h001 << sel;
        period_of = p[7:0] - CNT_ONE;
    endfunction : period_of

    // Counter reloads only at a period boundary, so a new divide waits for
    // the current period to end: no short period and no glitch
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (cmd.load && cmd.sel <= SEL_MAX) begin // RULE6
            st_nxt.pend = 1'b1;
            st_nxt.pend_period = period_of(cmd.sel); // RULE4
        end
        if (st_r.cnt == CNT_ZERO) begin
            st_nxt.tick = 1'b1; // RULE5
            if (st_nxt.pend) begin // RULE7
                st_nxt.period = st_nxt.pend_period;
                st_nxt.cnt = st_nxt.pend_period;
                st_nxt.pend = 1'b0;
            end else begin
                st_nxt.cnt = st_r.period;
            end
        end else begin
            st_nxt.cnt = st_r.cnt - CNT_ONE; // RULE8
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;

    // A new setting loaded at a boundary is pending for at most one period
    pending_bound_a: assert property (@(posedge clk) disable iff (!rst_sync_b)
        ce && st_r.pend && st_r.cnt == CNT_ZERO |=> !st_r.pend) // RULE7
        else $error("pending divide not applied at boundary");
endmodule : sysclk_prescaler
`default_nettype wire

//--- testbench/system_clock_prescaler_trim_test.sv
// Self-checking testbench for the clock control block
`default_nettype none
module system_clock_prescaler_trim_test
    import clk_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] TRIM_K = 8'h5A;

    typedef struct packed {
        logic [1:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } row_s;

    logic       clk;
    logic       rst_b;
    logic       ce;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       div8_fuse;
    logic       export_fuse;
    logic       gpio_out;
    logic       gpio_oe;
    logic       pin_o;
    logic       pin_oe;
    logic       sys_clk_en;
    logic [7:0] trim_o;
    logic       ext_drive;
    int         mismatches;
    int         checks_done;
    logic [8:0] v;
    row_s       rows [6];

    clock_control #(.FACTORY_TRIM(TRIM_K)) i_clock_control (
        .clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata),
        .start_div_eight_fuse(div8_fuse), .clock_export_fuse(export_fuse),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .clock_export_pin_o(pin_o), .clock_export_pin_oe(pin_oe),
        .sys_clk_en(sys_clk_en), .rc_osc_trim_o(trim_o),
        .timer_osc_ext_drive(ext_drive)
    );

    // 250 MHz master clock
    always #2 clk = ~clk;

    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One bus cycle, driven just after the rising edge
    task automatic bus(input logic w, input logic r, input logic [1:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
    endtask : bus

    task automatic idle(input int n);
        repeat (n) bus(1'b0, 1'b0, 2'h0, 8'h00);
    endtask : idle

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [1:0] a, output logic [8:0] r);
        bus(1'b0, 1'b1, a, 8'h00);
        idle(1);
        #1 r = {1'b0, rdata};
    endtask : rd_reg

    // Unlock, then the divide write gap cycles later
    task automatic div_set(input int gap, input logic [7:0] code);
        bus(1'b1, 1'b0, ADDR_DIVCTL, UNLOCK_WORD);
        idle(gap - 1);
        bus(1'b1, 1'b0, ADDR_DIVCTL, code);
        idle(1);
    endtask : div_set

    // Cycles to the next divided-clock tick, bounded
    task automatic tick_gap(output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (sys_clk_en !== 1'b1 && n < 600);
    endtask : tick_gap

    // Skips the switch-over periods, then measures one full period
    task automatic period(output logic [8:0] p);
        int n;
        repeat (4) tick_gap(n);
        p = 9'(n);
    endtask : period

    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (19) @(posedge clk);
        #1 chk({8'h00, pin_oe}, 9'h001);
        @(posedge clk);
        rst_b <= 1'b1;
        idle(4);
    endtask : do_reset

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    // Watchdog sized well above the expected run of a few thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        print_verdict();
    end

    initial begin
        clk = 1'b0; rst_b = 1'b0; ce = 1'b1; addr = 2'h0; wdata = 8'h00;
        wr = 1'b0; rd = 1'b0; div8_fuse = 1'b0; export_fuse = 1'b0;
        gpio_out = 1'b1; gpio_oe = 1'b1;
        mismatches = 0; checks_done = 0;
        rows = '{'{ADDR_TRIM, 8'h7F, 8'h7F}, '{ADDR_TRIM, 8'h80, 8'h80},
                 '{ADDR_TRIM, 8'h00, 8'h00}, '{ADDR_TIMERCFG, 8'h40, 8'h40},
                 '{ADDR_TIMERCFG, 8'h00, 8'h00}, '{2'h3, 8'h5A, 8'h00}};
        do_reset();
        rd_reg(ADDR_DIVCTL, v);
        chk(v, 9'h000);
        rd_reg(ADDR_TRIM, v);
        chk(v, {1'b0, TRIM_K});
        chk({8'h00, pin_o}, 9'h001);
        chk({8'h00, pin_oe}, 9'h001);
        $display("reset values done");
        // Plain register rows: write, read back, check the side output
        foreach (rows[i]) begin
            bus(1'b1, 1'b0, rows[i].a, rows[i].d);
            rd_reg(rows[i].a, v);
            chk(v, {1'b0, rows[i].e});
            if (rows[i].a == ADDR_TIMERCFG) chk({8'h00, ext_drive},
                                                {8'h00, rows[i].d[6]});
            if (rows[i].a == ADDR_TRIM) chk({1'b0, trim_o},
                                            {1'b0, rows[i].e});
        end
        $display("register rows done");
        // Every legal divide code, checked by read-back and tick spacing
        for (int k = 0; k <= 8; k++) begin
            div_set(1, 8'(k));
            rd_reg(ADDR_DIVCTL, v);
            chk(v, 9'(k));
            period(v);
            chk(v, 9'(1 << k));
        end
        $display("divide codes done");
        bus(1'b1, 1'b0, ADDR_DIVCTL, 8'h02);
        rd_reg(ADDR_DIVCTL, v);
        chk(v, 9'h008);
        div_set(6, 8'h02);
        rd_reg(ADDR_DIVCTL, v);
        chk(v, 9'h008);
        bus(1'b1, 1'b0, ADDR_DIVCTL, 8'h81);
        bus(1'b1, 1'b0, ADDR_DIVCTL, 8'h02);
        rd_reg(ADDR_DIVCTL, v);
        chk(v, 9'h008);
        // Second unlock inside the window must not restart it
        bus(1'b1, 1'b0, ADDR_DIVCTL, UNLOCK_WORD);
        idle(1);
        bus(1'b1, 1'b0, ADDR_DIVCTL, UNLOCK_WORD);
        rd_reg(ADDR_DIVCTL, v);
        chk(v, 9'h088);
        bus(1'b1, 1'b0, ADDR_DIVCTL, 8'h02);
        rd_reg(ADDR_DIVCTL, v);
        chk(v, 9'h008);
        div_set(3, 8'h75);
        rd_reg(ADDR_DIVCTL, v);
        chk(v, 9'h005);
        div_set(1, 8'h09);
        rd_reg(ADDR_DIVCTL, v);
        chk(v, 9'h009);
        period(v);
        chk(v, 9'h020);
        $display("unlock sequence done");
        export_fuse <= 1'b1;
        gpio_oe <= 1'b0;
        idle(3);
        chk({8'h00, pin_oe}, 9'h001);
        div8_fuse <= 1'b1;
        do_reset();
        rd_reg(ADDR_DIVCTL, v);
        chk(v, 9'h003);
        period(v);
        chk(v, 9'h008);
        div_set(1, 8'h00);
        rd_reg(ADDR_DIVCTL, v);
        chk(v, 9'h000);
        $display("fuse options done");
        // Clock enable low in the write cycle: the write must be lost
        bus(1'b1, 1'b0, ADDR_TRIM, 8'h11);
        ce <= 1'b0;
        idle(1);
        ce <= 1'b1;
        rd_reg(ADDR_TRIM, v);
        chk(v, {1'b0, TRIM_K});
        $display("clock enable done");
        print_verdict();
    end
endmodule : system_clock_prescaler_trim_test
`default_nettype wire
